// File: hdl/lci_cfg.svh
// offsets, field positions and reset values of the link change interrupt unit
`ifndef LCI_CFG_SVH
`define LCI_CFG_SVH
`define LCI_NUM_PORTS       5
`define LCI_STATUS_OFFSET   8'h7c
`define LCI_MASK_OFFSET     8'h7d
`define LCI_PORT_MSB        4
`define LCI_STATUS_RESET    5'h00
`define LCI_MASK_RESET      5'h00
`endif

// File: hdl/lci_edge_detect.sv
// per-port link state change detector
`include "lci_cfg.svh"
`default_nettype none
module lci_edge_detect
  import lci_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [`LCI_PORT_MSB:0]      link_up,
  output logic      [`LCI_PORT_MSB:0]      change
);
  logic [`LCI_PORT_MSB:0] prev_q;
  logic [`LCI_PORT_MSB:0] prev_d;
  logic                   armed_q;
  logic                   armed_d;

  // the first sampled state after reset is taken as reference, not as a change
  always_comb begin
    prev_d  = link_up;
    armed_d = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q  <= 5'h00;
      armed_q <= 1'b0;
    end else begin
      prev_q  <= prev_d;
      armed_q <= armed_d;
    end
  end

  // one comparator per port, each port sees only its own link
  genvar g;
  generate
    for (g = 0; g < `LCI_NUM_PORTS; g = g + 1) begin : g_port
      assign change[g] = armed_q & (link_up[g] ^ prev_q[g]);
    end
  endgenerate
endmodule
`default_nettype wire

// File: hdl/lci_link_change_irq.sv
// link change interrupt unit: sticky per-port status, mask and request output
//
// Functional notes
// - One sticky status bit per port, bit 0 for port 1 to bit 4 for port 5, set on link change.
// - Writing a one to a status bit clears it and writing zero leaves it alone.
// - A status bit reads one from its port's link change until cleared, whether or not the port is masked; all read zero after reset.
// - The mask register at 0x7d holds one bit per port in bits 4..0, one masks that port.
// - The mask bits are read and written by the host and reset to zero.
// - Each status bit is set only by its own port's link change.
`include "lci_cfg.svh"
`default_nettype none
module lci_link_change_irq
  import lci_pkg::*;
(
  input  wire logic                   CORE_CLK,
  input  wire logic                   RST,
  input  wire logic [`LCI_PORT_MSB:0] LINK_UP,
  input  wire logic                   REG_WR,
  input  wire logic                   REG_RD,
  input  wire logic [7:0]             REG_ADDR,
  input  wire logic [7:0]             REG_WDATA,
  output logic      [7:0]             REG_RDATA,
  output logic                        REG_HIT,
  output logic                        IRQ
);
  lci_reg_req_t           req;
  lci_sel_t               sel;
  logic [`LCI_PORT_MSB:0] change;
  logic [`LCI_PORT_MSB:0] status_q;
  logic [`LCI_PORT_MSB:0] status_d;
  logic [`LCI_PORT_MSB:0] mask_q;
  logic [`LCI_PORT_MSB:0] mask_d;
  logic [7:0]             rdata_q;
  logic [7:0]             rdata_d;
  logic                   irq_q;
  logic                   irq_d;

  logic                   wr_stat;
  logic                   wr_mask;
  logic                   rd_stat;
  logic                   rd_mask;
  logic [`LCI_PORT_MSB:0] clr_req;
  logic [`LCI_PORT_MSB:0] pend;

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  // address decode, used for both reads and writes
  function automatic lci_sel_t decode(input logic [7:0] a);
    if (a == `LCI_STATUS_OFFSET) begin
      return LCI_SEL_STAT;
    end else if (a == `LCI_MASK_OFFSET) begin
      return LCI_SEL_MASK;
    end
    return LCI_SEL_NONE;
  endfunction

  // strobe aimed at one register, shared by the write and read paths
  function automatic logic strobe_hit(input logic     stb,
                                      input lci_sel_t s,
                                      input lci_sel_t want);
    return stb && (s == want);
  endfunction

  // bundle the bus pins so the decode sees one coherent request
  assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};
  assign sel = decode(req.addr);

  // per-register strobes; an unmapped address raises none of them
  assign wr_stat = strobe_hit(req.wr, sel, LCI_SEL_STAT);
  assign wr_mask = strobe_hit(req.wr, sel, LCI_SEL_MASK);
  assign rd_stat = strobe_hit(req.rd, sel, LCI_SEL_STAT);
  assign rd_mask = strobe_hit(req.rd, sel, LCI_SEL_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // link change detection

  lci_edge_detect i_lci_edge_detect (
    .clk     (CORE_CLK),
    .rst     (RST),
    .link_up (LINK_UP),
    .change  (change)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sticky status

  // write one clears
  // only bits 4..0 can ask for a clear, reserved bits 7..5 are ignored
  assign clr_req = wr_stat ? req.wdata[`LCI_PORT_MSB:0] : 5'h00;

  // one sticky cell per port; each cell sees only its own change line
  genvar p;
  generate
    for (p = 0; p < `LCI_NUM_PORTS; p = p + 1) begin : g_stat
      // sticky set wins
      // a change in the clearing cycle keeps the bit, so no event is lost
      assign status_d[p] = (status_q[p] & ~clr_req[p]) | change[p];
    end
  endgenerate

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      status_q <= `LCI_STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mask register

  always_comb begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = req.wdata[`LCI_PORT_MSB:0];
    end
  end

  // mask resets to zero, all ports unmasked
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mask_q <= `LCI_MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  // read data, one cycle after the read strobe; reserved bits 7..5 read zero
  // data holds between reads, so a slow host may sample it late
  always_comb begin
    rdata_d = rdata_q;
    if (req.rd) begin
      unique case (sel)
        LCI_SEL_STAT: rdata_d = {3'h0, status_q};
        LCI_SEL_MASK: rdata_d = {3'h0, mask_q};
        LCI_SEL_NONE: rdata_d = 8'h00;
      endcase
    end
  end

  // read data register; a status read has no side effect on the cells
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request output

  // unmasked request
  // pending ports are those with status set and mask clear
  generate
    for (p = 0; p < `LCI_NUM_PORTS; p = p + 1) begin : g_pend
      assign pend[p] = status_q[p] & ~mask_q[p];
    end
  endgenerate

  // registered so the request pin never glitches; costs one cycle of lag
  always_comb begin
    irq_d = |pend;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // read strobes are decoded for symmetry; the mux above uses sel directly
  assign REG_RDATA = rdata_q;
  assign REG_HIT   = (sel != LCI_SEL_NONE); // combinational decode hit
  assign IRQ       = irq_q;

  // unused decoded read strobes kept for a later read side effect
  logic                   rd_unused;
  assign rd_unused = rd_stat | rd_mask;
endmodule
`default_nettype wire

// File: hdl/lci_pkg.sv
// types shared by the link change interrupt unit
`default_nettype none
package lci_pkg;
  // one register access from the switch's register path
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lci_reg_req_t;

  typedef enum logic [1:0] {
    LCI_SEL_NONE = 2'b00,
    LCI_SEL_STAT = 2'b01,
    LCI_SEL_MASK = 2'b10
  } lci_sel_t;
endpackage
`default_nettype wire

// File: verification/lci_asserts.sv
// port assertions of the link change interrupt unit
`default_nettype none
module lci_asserts (
  input wire logic       CORE_CLK,
  input wire logic       RST,
  input wire logic       REG_RD,
  input wire logic       REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_RDATA,
  input wire logic       REG_HIT,
  input wire logic       IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence rd_miss; REG_RD && !REG_HIT; endsequence
  sequence mask_all; REG_WR && REG_ADDR == 8'h7d && REG_WDATA[4:0] == 5'h1f; endsequence
  a_hit_decode: assert property (REG_HIT == (REG_ADDR inside {8'h7c, 8'h7d}))
    else $error("hit decode wrong");
  a_miss_zero: assert property (rd_miss |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_rsv_zero: assert property (REG_RD |=> REG_RDATA[7:5] == 3'h0)
    else $error("reserved read bits set");
  a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved");
  a_irq_quiet: assert property ($fell(RST) |-> !IRQ ##1 !IRQ)
    else $error("request after reset");
  a_mask_quiet: assert property (mask_all |-> ##2 !IRQ)
    else $error("request while all ports masked");
endmodule
`default_nettype wire

// File: verification/lci_link_mon.sv
// link state model of the five port monitors
`default_nettype none
module lci_link_mon (
  input wire logic       clk,
  input wire logic [4:0] flip,
  output var logic [4:0] link
);
  // each flip bit toggles that port's level; links start down
  initial link = 5'h00;
  always @(posedge clk) link <= link ^ flip;
endmodule
`default_nettype wire

// File: verification/tb_lci_link_change_irq.sv
// testbench of the link change interrupt unit
`default_nettype none
module tb_lci_link_change_irq;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wr = 0, rd = 0, hit, irq;
  logic [7:0] addr = 0, wd = 0, rdata;
  logic [4:0] flip = 0, link;
  int bad_count = 0, n_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  lci_link_mon i_lci_link_mon (.clk(clk), .flip(flip), .link(link));
  lci_link_change_irq i_lci_link_change_irq (.CORE_CLK(clk), .RST(rst), .LINK_UP(link),
    .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wd), .REG_RDATA(rdata),
    .REG_HIT(hit), .IRQ(irq));
  task automatic results;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, s);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wrt(input logic [7:0] a, d);
    @(posedge clk) #1; wr = 1; addr = a; wd = d;
    @(posedge clk) #1; wr = 0;
  endtask
  task automatic rdc(input logic [7:0] a, e);
    @(posedge clk) #1; rd = 1; addr = a;
    @(posedge clk) #1; rd = 0;
    chk("rdata", e, rdata);
  endtask
  // one link change on port k, then let it settle
  task automatic ev(input int k);
    @(posedge clk) #1; flip = 5'h01 << k;
    @(posedge clk) #1; flip = 5'h00;
    repeat (3) @(posedge clk);
  endtask
  // hang guard, the whole sequence needs about a hundred cycles
  always @(posedge clk) if (++cyc > 2000) begin
    bad_count++;
    results;
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 0;
    rdc(8'h7c, 8'h00);
    chk("hit", 8'h01, {7'h00, hit});
    rdc(8'h7d, 8'h00);
    for (int k = 0; k < 5; k++) begin
      ev(k);
      rdc(8'h7c, 8'h01 << k);
      chk("irq", 8'h01, {7'h00, irq});
      wrt(8'h7c, ~(8'h01 << k));
      rdc(8'h7c, 8'h01 << k);
      wrt(8'h7c, 8'h01 << k);
      rdc(8'h7c, 8'h00);
    end
    chk("irq", 8'h00, {7'h00, irq});
    wrt(8'h7d, 8'hff);
    rdc(8'h7d, 8'h1f);
    ev(4);
    chk("irq", 8'h00, {7'h00, irq});
    rdc(8'h7c, 8'h10);
    wrt(8'h7d, 8'h00);
    @(posedge clk) #1;
    chk("irq", 8'h01, {7'h00, irq});
    rdc(8'h7e, 8'h00);
    chk("hit", 8'h00, {7'h00, hit});
    results;
  end
endmodule
bind lci_link_change_irq lci_asserts i_lci_asserts (.CORE_CLK, .RST, .REG_RD, .REG_WR,
  .REG_WDATA, .REG_ADDR, .REG_RDATA, .REG_HIT, .IRQ);
`default_nettype wire
